// [tmr_pkg.sv]
package tmr_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h1;
  localparam logic [3:0] ADDR_RELOAD = 4'h2;
  localparam logic [3:0] ADDR_COMPARE = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h5;
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_PRE_LSB = 4;
  localparam int CTRL_AF_BIT = 7;
  localparam logic [1:0] MODE_ONESHOT = 2'h0;
  localparam logic [1:0] MODE_CONT = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  // ----------------------------------------------------------------
  // reset and restart values
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'hFFFF;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] PRE_ONE = 3'h0;
  localparam int STAT_RELOAD_BIT = 0;
  localparam int STAT_CMP_BIT = 1;
endpackage : tmr_pkg

// [tmr_top.sv]
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module tmr_top
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // external timer input, unused in these modes
  input wire logic ext_in_i,
  // timer pin and interrupt
  output logic tout_o,
  output logic tout_oe_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl;
  logic [15:0] count;
  logic [15:0] reload;
  logic [15:0] compare;
  logic [1:0] status;
  logic [1:0] mask;
  logic [6:0] pre_cnt;
  logic tout;
  logic enabled_q;

  // ----------------------------------------------------------------
  // field and strobe decode
  // ----------------------------------------------------------------
  // field decode
  wire en = ctrl[CTRL_EN_BIT];
  wire pol = ctrl[CTRL_POL_BIT];
  wire [1:0] mode = ctrl[CTRL_MODE_LSB +: 2];
  wire [2:0] pre_sel = ctrl[CTRL_PRE_LSB +: 3];
  wire af_en = ctrl[CTRL_AF_BIT];
  wire wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
  wire wr_count = wr_i && (addr_i == ADDR_COUNT);
  wire wr_reload = wr_i && (addr_i == ADDR_RELOAD);
  wire wr_cmp = wr_i && (addr_i == ADDR_COMPARE);
  wire wr_stat = wr_i && (addr_i == ADDR_STATUS);
  wire wr_mask = wr_i && (addr_i == ADDR_MASK);

  // ----------------------------------------------------------------
  // timer events
  // ----------------------------------------------------------------
  // prescale factor is 2**pre_sel; only the system clock feeds it, ext_in_i never counts
  wire [6:0] pre_lim = 7'((8'h01 << pre_sel) - 8'h01);
  wire tick = en && (pre_cnt == pre_lim);
  wire at_reload = tick && (count == reload);
  wire at_cmp = tick && (count == compare) && (mode == MODE_PWM);
  wire start = wr_ctrl && wdata_i[CTRL_EN_BIT] && !en;
  wire [1:0] events = {at_cmp, at_reload};
  wire unused_ext = ext_in_i;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // prescaler, restarted on enable so the first tick is a full prescale period
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_cnt <= 7'h00;
    end else if (!en || tick || start) begin
      pre_cnt <= 7'h00;
    end else begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // next count: reload restarts at 0001H in every mode, one-shot also stops
  // a direct count write beats the reload, so software can always reseed
  logic [15:0] next_count;
  logic next_en;
  always_comb begin
    next_count = count;
    next_en = en;
    if (wr_count) begin
      next_count = wdata_i;
    end else if (at_reload) begin
      next_count = COUNT_RESTART;
      if (mode == MODE_ONESHOT) begin
        next_en = 1'b0;
      end
    end else if (tick) begin
      next_count = count + 16'h0001;
    end
    if (wr_ctrl) begin
      next_en = wdata_i[CTRL_EN_BIT];
    end
  end

  // control and counter registers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= CTRL_RST;
      count <= COUNT_RST;
      reload <= RELOAD_RST;
      compare <= RELOAD_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wdata_i[7:0];
      end
      ctrl[CTRL_EN_BIT] <= next_en;
      count <= next_count;
      if (wr_reload) begin
        reload <= wdata_i;
      end
      if (wr_cmp) begin
        compare <= wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // timer output
  // ----------------------------------------------------------------
  // output level; holds while disabled except on a control write, pwm edges follow polarity
  // limitation: a polarity change while running only alters the next edge
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tout <= 1'b0;
    end else if (start && (wdata_i[CTRL_MODE_LSB +: 2] == MODE_PWM)) begin
      tout <= wdata_i[CTRL_POL_BIT];
    end else if (at_cmp) begin
      tout <= !pol;
    end else if (at_reload && (mode == MODE_PWM)) begin
      tout <= pol;
    end else if (at_reload) begin
      tout <= !tout;
    end else if (!en && wr_ctrl && (wdata_i[CTRL_MODE_LSB +: 2] == MODE_ONESHOT)) begin
      tout <= wdata_i[CTRL_POL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // status and mask
  // ----------------------------------------------------------------
  // sticky status, set wins over a write-one clear
  // so an event in the clear cycle is never lost
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status <= 2'h0;
      mask <= 2'h0;
      enabled_q <= 1'b0;
    end else begin
      status <= (status & ~(wr_stat ? wdata_i[1:0] : 2'h0)) | events;
      if (wr_mask) begin
        mask <= wdata_i[1:0];
      end
      enabled_q <= en;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // read mux, one cycle latency
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    case (addr_i)
      ADDR_CTRL: next_rdata = {8'h00, ctrl};
      ADDR_COUNT: next_rdata = count;
      ADDR_RELOAD: next_rdata = reload;
      ADDR_COMPARE: next_rdata = compare;
      ADDR_STATUS: next_rdata = {14'h0000, status};
      ADDR_MASK: next_rdata = {14'h0000, mask};
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= rd_i ? next_rdata : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // pin and interrupt
  // ----------------------------------------------------------------
  // pin: output enable follows the alternate-function enable
  assign tout_o = tout;
  assign tout_oe_o = af_en;
  assign irq_o = |(status & mask);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_reload_restart: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (at_reload && !wr_count) |=> (count == COUNT_RESTART))
    else $error("count did not restart at 0001 after reload");
  a_reload_flag: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    at_reload |=> status[STAT_RELOAD_BIT])
    else $error("reload flag not set");
  a_oneshot_stop: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (at_reload && mode == MODE_ONESHOT && !wr_ctrl) |=> !en)
    else $error("one-shot did not stop");
  a_cont_toggle: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (at_reload && mode == MODE_CONT && !wr_ctrl) |=> (tout != $past(tout)))
    else $error("continuous output did not toggle");
  a_pwm_cmp: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (at_cmp && !wr_ctrl) |=> (tout == !pol))
    else $error("pwm compare level wrong");
  a_pwm_reload: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (at_reload && mode == MODE_PWM && !at_cmp && !wr_ctrl) |=> (tout == pol))
    else $error("pwm reload level wrong");
  a_hold_off: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (!en && !wr_count) |=> (count == $past(count)))
    else $error("count moved while disabled");
  a_count_step: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (tick && !at_reload && !wr_count) |=> (count == $past(count) + 16'h0001))
    else $error("count did not advance by one");
  a_irq_level: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (at_reload && mask[STAT_RELOAD_BIT] && !wr_mask) |=> irq_o)
    else $error("interrupt level wrong");
  // compare match in pwm flags its own status bit
  a_cmp_flag: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    at_cmp |=> status[STAT_CMP_BIT])
    else $error("compare flag not set");
  // pwm start level is the written polarity
  a_pwm_start: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (start && wdata_i[CTRL_MODE_LSB +: 2] == MODE_PWM) |=> (tout == $past(wdata_i[CTRL_POL_BIT])))
    else $error("pwm start level wrong");
  // first enabled cycle never ticks unless the prescale factor is one
  a_first_tick: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (en && !enabled_q && pre_sel != PRE_ONE) |-> !tick)
    else $error("tick came before a full prescale period");
  // output frozen while disabled, except for a control write
  a_out_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (!en && !wr_ctrl) |=> (tout == $past(tout)))
    else $error("output moved while disabled");
  // read data stand only after a read strobe
  a_read_idle: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !rd_i |=> (rdata_o == 16'h0000))
    else $error("read data not idle");
  // count read returns the count of the strobe cycle
  a_read_count: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == ADDR_COUNT) |=> (rdata_o == $past(count)))
    else $error("count read wrong");
  // reload read returns the stored reload value
  a_read_reload: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == ADDR_RELOAD) |=> (rdata_o == $past(reload)))
    else $error("reload read wrong");
  // status read returns the sticky bits
  a_read_status: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == ADDR_STATUS) |=> (rdata_o[1:0] == $past(status)))
    else $error("status read wrong");
  // unmapped indices read as zero
  a_read_unmapped: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (rd_i && addr_i > ADDR_MASK) |=> (rdata_o == 16'h0000))
    else $error("unmapped read not zero");
  // mask write lands in one cycle
  a_mask_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr_mask |=> (mask == $past(wdata_i[1:0])))
    else $error("mask write lost");
  // write-one clear works when no event competes
  a_stat_clear: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (wr_stat && wdata_i[STAT_RELOAD_BIT] && !at_reload) |=> !status[STAT_RELOAD_BIT])
    else $error("reload flag not cleared");
  // reload write lands in one cycle
  a_reload_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr_reload |=> (reload == $past(wdata_i)))
    else $error("reload write lost");
  // compare write lands in one cycle
  a_cmp_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr_cmp |=> (compare == $past(wdata_i)))
    else $error("compare write lost");
  // a written start count replaces the count at once
  a_count_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr_count |=> (count == $past(wdata_i)))
    else $error("count write lost");
  // pin enable follows the written control bit
  a_ctrl_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr_ctrl |=> (tout_oe_o == $past(wdata_i[CTRL_AF_BIT])))
    else $error("output enable write lost");

endmodule : tmr_top

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import tmr_pkg::*;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ext_in_i = 1'b0;
  logic [15:0] rdata_o;
  logic tout_o;
  logic tout_oe_o;
  logic irq_o;
  int failures = 0;
  int checks_done = 0;
  int n;
  // ------------------------------------------------------------
  // clock, design
  // ------------------------------------------------------------
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  tmr_top dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_in_i(ext_in_i), .tout_o(tout_o),
    .tout_oe_o(tout_oe_o), .irq_o(irq_o));
  // ------------------------------------------------------------
  // bus tasks and checks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk("rdata", e, rdata_o);
  endtask : rd
  function automatic logic [15:0] ctl(logic en, logic pol, logic [1:0] m, logic [2:0] p);
    return {8'h00, 1'b1, p, m, pol, en};
  endfunction : ctl
  // cycles from now to the next edge of tout into level lv, bounded
  task automatic per(input logic lv, output int c);
    c = 0;
    while (tout_o !== ~lv && c < 400) begin
      @(negedge mclk_i);
      c++;
    end
    while (tout_o !== lv && c < 400) begin
      @(negedge mclk_i);
      c++;
    end
    if (c >= 400) print_verdict(1);
  endtask : per
  task automatic print_verdict(input bit hung);
    if (hung) failures++;
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    rd(ADDR_RELOAD, 16'hFFFF);
    rd(ADDR_COUNT, 16'h0000);
    rd(4'h9, 16'h0000);
    // continuous: toggle at every reload, period twice reload clocks
    wr(ADDR_CTRL, ctl(1'b0, 1'b0, MODE_CONT, 3'h0));
    wr(ADDR_COUNT, 16'h0001);
    wr(ADDR_RELOAD, 16'h0003);
    wr(ADDR_MASK, 16'h0001);
    wr(ADDR_CTRL, ctl(1'b1, 1'b0, MODE_CONT, 3'h0));
    per(1'b1, n);
    per(1'b1, n);
    chk("toggle period", 16'd6, 16'(n));
    chk("irq", 16'h0001, {15'h0, irq_o});
    wr(ADDR_CTRL, ctl(1'b0, 1'b0, MODE_CONT, 3'h0));
    rd(ADDR_STATUS, 16'h0001);
    wr(ADDR_STATUS, 16'h0001);
    @(negedge mclk_i);
    chk("irq clear", 16'h0000, {15'h0, irq_o});
    // one-shot: start 2, reload 6, prescale 2
    wr(ADDR_COUNT, 16'h0002);
    wr(ADDR_RELOAD, 16'h0006);
    rd(ADDR_COUNT, 16'h0002);
    wr(ADDR_CTRL, ctl(1'b0, 1'b0, MODE_ONESHOT, 3'h1));
    wr(ADDR_CTRL, ctl(1'b1, 1'b0, MODE_ONESHOT, 3'h1));
    wr(ADDR_CTRL, ctl(1'b1, 1'b1, MODE_ONESHOT, 3'h1));
    n = 0;
    while (irq_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    checks_done++;
    if (n < 8 || n > 10) begin
      failures++;
      $display("wrong value oneshot time expected %0d seen %0d", 8, n);
    end
    chk("oneshot out", 16'h0001, {15'h0, tout_o});
    rd(ADDR_CTRL, ctl(1'b0, 1'b1, MODE_ONESHOT, 3'h1));
    rd(ADDR_COUNT, 16'h0001);
    // pwm, both polarities; period is reload times prescale
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_CTRL, ctl(1'b0, p[0], MODE_PWM, p[0] ? 3'h0 : 3'h2));
      wr(ADDR_COUNT, 16'h0001);
      wr(ADDR_COMPARE, 16'h0002);
      wr(ADDR_RELOAD, 16'h0005);
      wr(ADDR_CTRL, ctl(1'b1, p[0], MODE_PWM, p[0] ? 3'h0 : 3'h2));
      @(negedge mclk_i);
      chk("pwm start", {15'h0, p[0]}, {15'h0, tout_o});
      per(p[0], n);
      per(p[0], n);
      chk("pwm period", p[0] ? 16'd5 : 16'd20, 16'(n));
      chk("pwm oe", 16'h0001, {15'h0, tout_oe_o});
    end
    rd(ADDR_STATUS, 16'h0003);
    rd(ADDR_MASK, 16'h0001);
    print_verdict(0);
  end
endmodule : tb_top
